//--- lra_pkg.sv
package lra_pkg;

  // RAM geometry
  localparam int ROW_BYTES = 13;
  localparam int ROW_W = 104;
  localparam int DOT_ROWS = 52;
  localparam int SEG_N = 100;
  localparam int COM_N = 51;
  localparam logic [3:0] X_LAST = 4'hc;
  localparam logic [5:0] Y_LAST = 6'h33;
  localparam logic [5:0] Y40_GAP_FROM = 6'h12;
  localparam logic [5:0] Y40_GAP_TO = 6'h1a;
  localparam logic [5:0] Y40_LAST = 6'h2c;
  localparam logic [7:0] LAST_BYTE_MASK = 8'hf0;
  localparam logic [6:0] LANE_TOP = 7'h60;

  // RAM select field of the address byte
  localparam logic [1:0] RAM_DOT = 2'h0;
  localparam logic [1:0] RAM_ICON = 2'h1;
  localparam logic [1:0] RAM_BLINK = 2'h2;

  // Command encodings
  localparam logic [7:0] OP_RESET = 8'h27;
  localparam logic [7:0] OP_DAC = 8'h28;
  localparam logic [4:0] OP_DISP = 5'h01;
  localparam logic [4:0] OP_STBY = 5'h02;
  localparam logic [4:0] OP_DUTY = 5'h03;
  localparam logic [4:0] OP_BLINK = 5'h08;
  localparam logic [4:0] OP_RW = 5'h16;
  localparam logic [4:0] OP_TEST = 5'h17;
  localparam logic [1:0] OP_ADDR = 2'h3;

  // Field positions inside command bytes
  localparam int RW_READ_BIT = 2;
  localparam int RW_CLR_BIT = 1;
  localparam int RW_HOLD_BIT = 0;
  localparam int DUTY40_BIT = 0;
  localparam int DISP_ON_BIT = 0;
  localparam int STBY_BIT = 0;

  // Scan slot layout
  localparam logic [5:0] SLOTS53_LAST = 6'h34;
  localparam logic [5:0] SLOTS40_LAST = 6'h27;
  localparam logic [5:0] ICON53_SLOT = 6'h33;
  localparam logic [5:0] ICON40_SLOT = 6'h26;
  localparam logic [5:0] GAP40_SLOT = 6'h13;
  localparam logic [5:0] GAP40_SKIP = 6'h07;

  // Command settings held by the device
  typedef struct packed {
    logic [2:0] disp;
    logic [2:0] stby;
    logic [2:0] duty;
    logic [2:0] blink;
    logic [2:0] rw;
    logic [2:0] test;
    logic [5:0] dac;
  } lra_cfg_t;

  localparam lra_cfg_t CFG_RESET = '{disp: 3'h0, stby: 3'h0, duty: 3'h0, blink: 3'h0,
                                     rw: 3'h0, test: 3'h0, dac: 6'h20};

  typedef enum logic [2:0] {ST_CMD, ST_DAC, ST_AX, ST_AY, ST_DATA} lra_pstate_t;

endpackage

//--- lra_core.sv
module lra_core #(
  parameter int COM_CYCLES = 16,
  parameter int BLINK_FRAMES = 32
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Host byte port
  input wire logic transfer_strobe,
  input wire logic byte_valid,
  input wire logic [7:0] byte_in,
  output logic [7:0] read_byte,
  output logic read_valid,
  // Mode pins
  input wire logic contrast_dac_use_pin,
  input wire logic ext_supply_pin,
  input wire logic follower_mode_pin,
  // Analog control
  output logic [5:0] dac_code,
  output logic dac_enable,
  output logic amp_enable,
  output logic follower_level_cap,
  output logic [2:0] test_mode,
  // LCD drive
  output logic [50:0] dot_common_outputs,
  output logic icon_common_output,
  output logic [99:0] segment_outputs
);

  generate
    if (COM_CYCLES < 1 || BLINK_FRAMES < 1) begin : g_bad
      $error("lra_core: COM_CYCLES and BLINK_FRAMES must be at least 1");
    end
  endgenerate

  localparam int PW = $clog2(COM_CYCLES + 1);
  localparam int FW = $clog2(BLINK_FRAMES + 1);

  lra_pkg::lra_cfg_t cfg;
  lra_pkg::lra_pstate_t st;
  logic strobe_q;
  logic [1:0] ram_sel;
  logic [3:0] x_ptr;
  logic [5:0] y_ptr;
  logic read_mode;
  logic [lra_pkg::ROW_W-1:0] dot_row [0:lra_pkg::DOT_ROWS-1];
  logic [lra_pkg::ROW_W-1:0] icon_row;
  logic [lra_pkg::ROW_W-1:0] blink_row;

  ////////////////////////////////////////////////////////////////////////
  // Host byte decode

  logic take;
  logic strobe_rise;
  logic is_addr;
  logic is_rw;
  logic [6:0] lane_lo;
  logic addr_ok;

  assign take = byte_valid & ~transfer_strobe;
  assign strobe_rise = transfer_strobe & ~strobe_q;
  assign is_addr = byte_in[7:6] == lra_pkg::OP_ADDR;
  assign is_rw = byte_in[7:3] == lra_pkg::OP_RW;
  assign lane_lo = lra_pkg::LANE_TOP - {x_ptr, 3'b000};
  assign addr_ok = (x_ptr <= lra_pkg::X_LAST) && (y_ptr <= lra_pkg::Y_LAST);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      strobe_q <= 1'b1;
    end else begin
      strobe_q <= transfer_strobe;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= lra_pkg::ST_CMD;
    end else if (strobe_rise) begin
      st <= lra_pkg::ST_CMD;
    end else if (take) begin
      unique case (st)
        lra_pkg::ST_CMD: begin
          if (byte_in == lra_pkg::OP_DAC) begin
            st <= lra_pkg::ST_DAC;
          end else if (is_addr) begin
            st <= lra_pkg::ST_AX;
          end else if (is_rw) begin
            st <= lra_pkg::ST_DATA;
          end
        end
        lra_pkg::ST_DAC: st <= lra_pkg::ST_CMD;
        lra_pkg::ST_AX: st <= lra_pkg::ST_AY;
        lra_pkg::ST_AY: st <= lra_pkg::ST_CMD;
        lra_pkg::ST_DATA: st <= lra_pkg::ST_DATA;
      endcase
    end
  end

  // Command settings
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg <= lra_pkg::CFG_RESET;
    end else if (take && st == lra_pkg::ST_DAC) begin
      cfg.dac <= byte_in[5:0];
    end else if (take && st == lra_pkg::ST_CMD) begin
      if (byte_in == lra_pkg::OP_RESET) begin
        cfg <= lra_pkg::CFG_RESET;
      end else begin
        unique case (byte_in[7:3])
          lra_pkg::OP_DISP: cfg.disp <= byte_in[2:0];
          lra_pkg::OP_STBY: cfg.stby <= byte_in[2:0];
          lra_pkg::OP_DUTY: cfg.duty <= {byte_in[3:2], byte_in[0]};
          lra_pkg::OP_BLINK: cfg.blink <= byte_in[2:0];
          lra_pkg::OP_RW: cfg.rw <= byte_in[2:0];
          lra_pkg::OP_TEST: cfg.test <= byte_in[2:0];
          default: cfg <= cfg;
        endcase
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      read_mode <= 1'b0;
    end else if (strobe_rise) begin
      read_mode <= 1'b0;
    end else if (take && st == lra_pkg::ST_CMD && byte_in == lra_pkg::OP_RESET) begin
      read_mode <= 1'b0;
    end else if (take && st == lra_pkg::ST_CMD && is_rw) begin
      read_mode <= byte_in[lra_pkg::RW_READ_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address counters

  logic duty40;
  logic [3:0] next_x;
  logic [5:0] next_y;

  assign duty40 = cfg.duty[lra_pkg::DUTY40_BIT];

  always_comb begin
    next_x = x_ptr + 4'h1;
    next_y = y_ptr;
    if (x_ptr >= lra_pkg::X_LAST) begin
      next_x = 4'h0;
      if (ram_sel != lra_pkg::RAM_DOT) begin
        next_y = 6'h00;
      end else if (duty40 && y_ptr == lra_pkg::Y40_GAP_FROM) begin
        next_y = lra_pkg::Y40_GAP_TO;
      end else if (duty40 && y_ptr >= lra_pkg::Y40_LAST) begin
        next_y = 6'h00;
      end else if (y_ptr >= lra_pkg::Y_LAST) begin
        next_y = 6'h00;
      end else begin
        next_y = y_ptr + 6'h01;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ram_sel <= lra_pkg::RAM_DOT;
      x_ptr <= 4'h0;
      y_ptr <= 6'h00;
    end else if (take) begin
      unique case (st)
        lra_pkg::ST_CMD: begin
          if (is_addr) begin
            ram_sel <= byte_in[5:4];
          end else if (is_rw && byte_in[lra_pkg::RW_CLR_BIT]) begin
            x_ptr <= 4'h0;
            y_ptr <= 6'h00;
          end
        end
        lra_pkg::ST_AX: x_ptr <= byte_in[3:0];
        lra_pkg::ST_AY: y_ptr <= (ram_sel == lra_pkg::RAM_DOT) ? byte_in[5:0] : 6'h00;
        lra_pkg::ST_DATA: begin
          if (!cfg.rw[lra_pkg::RW_HOLD_BIT]) begin
            x_ptr <= next_x;
            y_ptr <= next_y;
          end
        end
        default: x_ptr <= x_ptr;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // RAM access, host side

  logic host_wr;
  logic [7:0] wr_byte;

  assign host_wr = take && st == lra_pkg::ST_DATA && !read_mode && addr_ok;
  assign wr_byte = (x_ptr == lra_pkg::X_LAST) ? (byte_in & lra_pkg::LAST_BYTE_MASK) : byte_in;

  // Single write port; the scan only reads, so no write is lost
  always_ff @(posedge mclk) begin
    if (host_wr) begin
      unique case (ram_sel)
        lra_pkg::RAM_ICON: icon_row[lane_lo +: 8] <= wr_byte;
        lra_pkg::RAM_BLINK: blink_row[lane_lo +: 8] <= wr_byte;
        default: dot_row[y_ptr][lane_lo +: 8] <= wr_byte;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      read_byte <= 8'h00;
      read_valid <= 1'b0;
    end else begin
      read_valid <= take && st == lra_pkg::ST_DATA && read_mode;
      if (take && st == lra_pkg::ST_DATA && read_mode) begin
        unique case (ram_sel)
          lra_pkg::RAM_ICON: read_byte <= icon_row[lane_lo +: 8];
          lra_pkg::RAM_BLINK: read_byte <= blink_row[lane_lo +: 8];
          default: read_byte <= addr_ok ? dot_row[y_ptr][lane_lo +: 8] : 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Common scan

  logic [PW-1:0] per_cnt;
  logic [5:0] slot;
  logic [FW-1:0] frame_cnt;
  logic blink_off;
  logic slot_end;
  logic frame_end;
  logic [5:0] slot_last;

  assign slot_last = duty40 ? lra_pkg::SLOTS40_LAST : lra_pkg::SLOTS53_LAST;
  assign slot_end = per_cnt == PW'(COM_CYCLES - 1);
  assign frame_end = slot_end && slot >= slot_last;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      per_cnt <= '0;
      slot <= 6'h00;
    end else if (slot_end) begin
      per_cnt <= '0;
      slot <= frame_end ? 6'h00 : slot + 6'h01;
    end else begin
      per_cnt <= per_cnt + PW'(1);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      frame_cnt <= '0;
      blink_off <= 1'b0;
    end else if (cfg.blink == 3'h0) begin
      frame_cnt <= '0;
      blink_off <= 1'b0;
    end else if (frame_end) begin
      if (frame_cnt == FW'(BLINK_FRAMES - 1)) begin
        frame_cnt <= '0;
        blink_off <= ~blink_off;
      end else begin
        frame_cnt <= frame_cnt + FW'(1);
      end
    end
  end

  logic is_dot;
  logic is_icon;
  logic [5:0] scan_row;
  logic [lra_pkg::ROW_W-1:0] src_row;
  logic [lra_pkg::SEG_N-1:0] next_seg;
  logic shown;

  always_comb begin
    is_icon = slot == (duty40 ? lra_pkg::ICON40_SLOT : lra_pkg::ICON53_SLOT);
    if (duty40) begin
      is_dot = slot < lra_pkg::ICON40_SLOT;
      scan_row = (slot < lra_pkg::GAP40_SLOT) ? slot : slot + lra_pkg::GAP40_SKIP;
    end else begin
      is_dot = slot < lra_pkg::ICON53_SLOT;
      scan_row = slot;
    end
    if (is_icon) begin
      src_row = icon_row & ~(blink_row & {lra_pkg::ROW_W{blink_off}});
    end else if (is_dot) begin
      src_row = dot_row[scan_row];
    end else begin
      src_row = '0;
    end
  end

  // Segment k takes row bit 104-k, so byte 0 bit 7 lands on segment 1
  genvar gi;
  generate
    for (gi = 0; gi < lra_pkg::SEG_N; gi++) begin : g_seg
      assign next_seg[gi] = src_row[lra_pkg::ROW_W - 1 - gi];
    end
  endgenerate

  assign shown = cfg.disp[lra_pkg::DISP_ON_BIT] && !cfg.stby[lra_pkg::STBY_BIT];

  // Common pulse and its row data are registered together
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dot_common_outputs <= '0;
      icon_common_output <= 1'b0;
      segment_outputs <= '0;
    end else begin
      dot_common_outputs <= '0;
      icon_common_output <= shown && is_icon;
      segment_outputs <= shown ? next_seg : '0;
      if (shown && is_dot) begin
        dot_common_outputs[scan_row] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Contrast and supply control

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dac_code <= 6'h00;
      dac_enable <= 1'b0;
      amp_enable <= 1'b0;
      follower_level_cap <= 1'b0;
      test_mode <= 3'h0;
    end else begin
      amp_enable <= ~ext_supply_pin;
      dac_enable <= contrast_dac_use_pin & ~ext_supply_pin;
      dac_code <= (contrast_dac_use_pin & ~ext_supply_pin) ? cfg.dac : 6'h00;
      follower_level_cap <= follower_mode_pin;
      test_mode <= cfg.test;
    end
  end

endmodule

//--- lra_core_asserts.sv
module lra_core_asserts #(
  parameter int COM_CYCLES = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Host port
  input wire logic transfer_strobe,
  input wire logic byte_valid,
  input wire logic read_valid,
  // Mode pins and analog control
  input wire logic contrast_dac_use_pin,
  input wire logic ext_supply_pin,
  input wire logic [5:0] dac_code,
  input wire logic dac_enable,
  input wire logic amp_enable,
  // Commons
  input wire logic [50:0] dot_common_outputs,
  input wire logic icon_common_output
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // Length of the current icon select pulse
  int icon_run;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) icon_run <= 0;
    else if (icon_common_output) icon_run <= icon_run + 1;
    else icon_run <= 0;
  end

  chk_one_common: assert property ($onehot0({dot_common_outputs, icon_common_output}))
    else $error("more than one common selected");
  chk_icon_pulse_len: assert property (icon_common_output |-> icon_run < COM_CYCLES)
    else $error("icon select pulse too long");
  chk_ext_supply_off: assert property (ext_supply_pin |=> !amp_enable && !dac_enable && dac_code == 6'h00)
    else $error("analog stays on with external supply");
  chk_amp_internal: assert property (!ext_supply_pin |=> amp_enable)
    else $error("amplifier off with internal supply");
  chk_dac_in_use: assert property (contrast_dac_use_pin && !ext_supply_pin |=> dac_enable)
    else $error("converter not enabled");
  chk_dac_pin_low: assert property (!contrast_dac_use_pin |=> !dac_enable)
    else $error("converter enabled while unused");
  chk_dac_code_idle: assert property (!dac_enable |-> dac_code == 6'h00)
    else $error("contrast code shown while converter off");
  chk_read_cause: assert property (read_valid |-> $past(byte_valid) && !$past(transfer_strobe))
    else $error("read answer without a selected request");

  cover property (read_valid);
  cover property ($rose(icon_common_output));
  cover property (ext_supply_pin ##1 !ext_supply_pin);
endmodule

bind lra_core lra_core_asserts #(.COM_CYCLES(COM_CYCLES)) lra_core_asserts_i (
  .mclk, .rst, .transfer_strobe, .byte_valid, .read_valid, .contrast_dac_use_pin, .ext_supply_pin,
  .dac_code, .dac_enable, .amp_enable, .dot_common_outputs, .icon_common_output);

//--- lra_host.sv
module lra_host (
  // Clock
  input wire logic mclk,
  // Byte port toward the device
  output logic transfer_strobe,
  output logic byte_valid,
  output logic [7:0] byte_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    transfer_strobe = 1'b1;
    byte_valid = 1'b0;
    byte_in = 8'h00;
  end

  task automatic open_xfer();
    @(negedge mclk);
    transfer_strobe = 1'b0;
  endtask

  task automatic close_xfer();
    @(negedge mclk);
    transfer_strobe = 1'b1;
  endtask

  // Released data shows the inverse of the last byte
  task automatic put(input logic [7:0] b);
    @(negedge mclk);
    byte_valid = 1'b1;
    byte_in = b;
    @(negedge mclk);
    byte_valid = 1'b0;
    byte_in = ~b;
  endtask

  task automatic set_addr(input logic [7:0] sel, input logic [7:0] x, input logic [7:0] y);
    put(sel);
    put(x);
    put(y);
  endtask
endmodule

//--- lra_core_tb.sv
module lra_core_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk;
  logic rst;
  logic contrast_dac_use_pin;
  logic ext_supply_pin;
  logic follower_mode_pin;
  logic transfer_strobe, byte_valid, read_valid, dac_enable, amp_enable, icon_common_output;
  logic follower_level_cap;
  logic [7:0] byte_in, read_byte;
  logic [5:0] dac_code;
  logic [2:0] test_mode;
  logic [50:0] dot_common_outputs;
  logic [99:0] segment_outputs;
  int n_mismatch = 0;
  int checks = 0;

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  lra_host lra_host_i (.mclk, .transfer_strobe, .byte_valid, .byte_in);

  lra_core #(.COM_CYCLES(2), .BLINK_FRAMES(2)) lra_core_i (
    .mclk, .rst, .transfer_strobe, .byte_valid, .byte_in, .read_byte, .read_valid,
    .contrast_dac_use_pin, .ext_supply_pin, .follower_mode_pin, .dac_code, .dac_enable, .amp_enable,
    .follower_level_cap, .test_mode, .dot_common_outputs, .icon_common_output, .segment_outputs);

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmd(input logic [7:0] b);
    lra_host_i.open_xfer();
    lra_host_i.put(b);
    lra_host_i.close_xfer();
  endtask

  // Write two bytes from X 0CH onward, then read both back
  task automatic pair(input logic [7:0] sel, input logic [7:0] y, input logic [7:0] d0,
                      input logic [7:0] d1, input logic [7:0] e0);
    lra_host_i.open_xfer();
    lra_host_i.set_addr(sel, 8'h0c, y);
    lra_host_i.put(8'hb0);
    lra_host_i.put(d0);
    lra_host_i.put(d1);
    lra_host_i.close_xfer();
    lra_host_i.open_xfer();
    lra_host_i.set_addr(sel, 8'h0c, y);
    lra_host_i.put(8'hb4);
    lra_host_i.put(8'h00);
    chk(read_byte, e0);
    chk(read_valid, 1'b1);
    lra_host_i.put(8'h00);
    chk(read_byte, d1);
    lra_host_i.close_xfer();
  endtask

  // One frame of commons after two settling frames
  task automatic scan(input int frame, input logic [50:0] mask, input int hi);
    logic [50:0] seen_or;
    int n;
    int ni;
    seen_or = '0;
    n = 0;
    ni = 0;
    repeat (2 * frame) @(negedge mclk);
    repeat (frame) begin
      @(negedge mclk);
      seen_or |= dot_common_outputs;
      n += $countones(dot_common_outputs);
      ni += int'(icon_common_output);
      if (dot_common_outputs[0] === 1'b1) chk(segment_outputs[7:0], 8'h55);
      if (icon_common_output === 1'b1) chk(segment_outputs[99:96], 4'hf);
    end
    chk(seen_or, mask);
    chk(n, hi);
    chk(ni, 2);
  endtask

  // Icon cycles with the top nibble shown and masked over four frames
  task automatic blink(input int frame);
    int n_on;
    int n_off;
    n_on = 0;
    n_off = 0;
    repeat (4 * frame) begin
      @(negedge mclk);
      if (icon_common_output === 1'b1 && segment_outputs[99:96] === 4'hf) n_on++;
      if (icon_common_output === 1'b1 && segment_outputs[99:96] === 4'h0) n_off++;
    end
    chk(n_on, 4);
    chk(n_off, 4);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    contrast_dac_use_pin = 1'b1;
    ext_supply_pin = 1'b0;
    follower_mode_pin = 1'b0;
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    repeat (2) @(negedge mclk);
    chk(dac_code, 6'h20);
    pair(8'hc0, 8'h33, 8'hff, 8'haa, 8'hf0);
    pair(8'hd0, 8'h05, 8'hff, 8'haa, 8'hf0);
    pair(8'he0, 8'h05, 8'hff, 8'haa, 8'hf0);
    cmd(8'h0f);
    scan(106, {51{1'b1}}, 102);
    cmd(8'h19);
    scan(80, 51'h7ffff | (51'h7ffff << 26), 76);
    pair(8'hc0, 8'h12, 8'h33, 8'h44, 8'h30);
    lra_host_i.open_xfer();
    lra_host_i.put(8'h28);
    lra_host_i.put(8'h15);
    lra_host_i.close_xfer();
    @(negedge mclk);
    chk(dac_code, 6'h15);
    ext_supply_pin = 1'b1;
    follower_mode_pin = 1'b1;
    repeat (2) @(negedge mclk);
    chk({dac_code, dac_enable, amp_enable}, 8'h00);
    chk(follower_level_cap, 1'b1);
    ext_supply_pin = 1'b0;
    contrast_dac_use_pin = 1'b0;
    repeat (2) @(negedge mclk);
    chk({dac_code, dac_enable, amp_enable}, 8'h01);
    contrast_dac_use_pin = 1'b1;
    cmd(8'hbb);
    chk(test_mode, 3'h3);
    cmd(8'h27);
    @(negedge mclk);
    chk(dac_code, 6'h20);
    chk(test_mode, 3'h0);
    cmd(8'h0f);
    scan(106, {51{1'b1}}, 102);
    cmd(8'h11);
    repeat (2) @(negedge mclk);
    chk({dot_common_outputs, icon_common_output, segment_outputs[7:0]}, 60'h0);
    cmd(8'h10);
    cmd(8'h41);
    blink(106);
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    end_sim();
  end
endmodule
